// >>> rtl/tcs_source_select.sv
// Behaviour
// RULE1 - 4-bit clock selector: 0 pin, 1 sysclk/4, 2 sysclk; 7, E, F reserved
// RULE2 - clock codes 3..6 pick high, low, medium 500k and medium 32k oscillators
// RULE3 - clock code 8 reference clock, 9 timer0 overflow, A..D logic cells 1..4
// RULE4 - 5-bit gate selector: 0 pin; codes 10001..11111 reserved
// RULE5 - gate codes 1..4: timer0 overflow, period pulse, capture/compare one, two
// RULE6 - both selectors clear on power-on/brown-out reset, keep value otherwise
// RULE7 - unused upper selector bits ignore writes and read as zero
// RULE8 - gate 5..8 pwm 3..6, 9 nco, A/B comparators, C zero-cross, D..10 cells
// RULE9 - system clock sources bypass synchronisation regardless of sync setting
`timescale 1ns/1ps
`default_nettype none

module tcs_source_select (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    por_bor_rst_n,
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    sync_disable,
    input  wire logic                    clock_pin_input_map,
    input  wire logic                    gate_pin_input_map,
    input  wire logic                    sys_div4_tick,
    input  wire tcs_pkg::tcs_clk_srcs_t  clk_srcs,
    input  wire tcs_pkg::tcs_gate_srcs_t gate_srcs,
    output logic                         count_clock,
    output logic                         count_clock_valid,
    output logic                         count_clock_bypass_sync,
    output logic                         count_gate
);

    // pin-side inputs cross two flops before any selection
    logic [1:0] clk_pin_meta_q, clk_pin_meta_d;
    logic [1:0] gate_pin_meta_q, gate_pin_meta_d;

    logic [tcs_pkg::CLK_CODE_W-1:0]  clk_sel_q, clk_sel_d;
    logic [tcs_pkg::GATE_CODE_W-1:0] gate_sel_q, gate_sel_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wait_q, wait_d;
    logic        clk_q, clk_d;
    logic        clk_valid_q, clk_valid_d;
    logic        bypass_q, bypass_d;
    logic        gate_q, gate_d;

    logic        access;
    logic        wr_commit;
    logic        clk_hit;
    logic        gate_hit;
    logic [4:0]  lc_idx_c;
    logic [4:0]  lc_idx_g;
    logic [4:0]  pwm_idx;

    assign access   = (avs_read | avs_write) & wait_q;
    // a write lands only at the edge at which the master sees waitrequest low
    assign wr_commit = avs_write & ~wait_q & avs_byteenable[0];
    assign clk_hit  = avs_address == tcs_pkg::CLK_SEL_OFFSET;
    assign gate_hit = avs_address == tcs_pkg::GATE_SEL_OFFSET;
    assign lc_idx_c = {1'b0, clk_sel_q - tcs_pkg::CLK_LC_FIRST};
    assign lc_idx_g = gate_sel_q - tcs_pkg::GATE_LC_FIRST;
    assign pwm_idx  = gate_sel_q - tcs_pkg::GATE_PWM_FIRST;

    always_comb begin
        clk_pin_meta_d  = {clk_pin_meta_q[0], clock_pin_input_map};
        gate_pin_meta_d = {gate_pin_meta_q[0], gate_pin_input_map};
    end

    // one wait cycle per access: waitrequest drops the cycle after the request rises
    always_comb begin
        clk_sel_d  = clk_sel_q;
        gate_sel_d = gate_sel_q;
        rdata_d    = rdata_q;
        wait_d     = 1'b1;
        if (access) begin
            wait_d = 1'b0;
            if (avs_read) begin
                // unmapped offsets read zero
                rdata_d = 32'h0000_0000;
                if (clk_hit) begin
                    rdata_d = {28'h000_0000, clk_sel_q}; // RULE7
                end else if (gate_hit) begin
                    rdata_d = {27'h000_0000, gate_sel_q}; // RULE7
                end
            end
        end
        // upper write bits are dropped here, so they can never reach a read
        if (wr_commit) begin
            if (clk_hit) begin
                clk_sel_d = avs_writedata[tcs_pkg::CLK_CODE_W-1:0]; // RULE7
            end
            if (gate_hit) begin
                gate_sel_d = avs_writedata[tcs_pkg::GATE_CODE_W-1:0]; // RULE7
            end
        end
    end

    // clock source mux; reserved codes give a stopped, invalid clock
    always_comb begin
        clk_d       = 1'b0;
        clk_valid_d = 1'b1;
        bypass_d    = sync_disable;
        unique case (clk_sel_q)
            tcs_pkg::CLK_PIN:      clk_d = clk_pin_meta_q[1]; // RULE1
            tcs_pkg::CLK_SYS_DIV4: begin
                clk_d    = sys_div4_tick; // RULE1
                bypass_d = 1'b1; // RULE9
            end
            tcs_pkg::CLK_SYS:      begin
                clk_d    = 1'b1; // RULE1
                bypass_d = 1'b1; // RULE9
            end
            tcs_pkg::CLK_HFOSC:    clk_d = clk_srcs.hf_osc; // RULE2
            tcs_pkg::CLK_LFOSC:    clk_d = clk_srcs.lf_osc; // RULE2
            tcs_pkg::CLK_MF500K:   clk_d = clk_srcs.mf_500k; // RULE2
            tcs_pkg::CLK_MF32K:    clk_d = clk_srcs.mf_32k; // RULE2
            tcs_pkg::CLK_REFCLK:   clk_d = clk_srcs.ref_clk; // RULE3
            tcs_pkg::CLK_TMR0_OVF: clk_d = clk_srcs.tmr0_ovf; // RULE3
            tcs_pkg::CLK_LC_FIRST,
            tcs_pkg::CLK_LC_FIRST + 4'h1,
            tcs_pkg::CLK_LC_FIRST + 4'h2,
            tcs_pkg::CLK_LC_LAST: begin
                clk_d = clk_srcs.logic_cell[lc_idx_c[1:0]]; // RULE3
            end
            default:               clk_valid_d = 1'b0; // RULE1
        endcase
    end

    // gate source mux; reserved codes hold the gate low
    // the pwm and cell indices keep only two bits: the range tests in front of
    // each lookup guarantee the offset is below four
    always_comb begin
        gate_d = 1'b0;
        if (gate_sel_q == tcs_pkg::GATE_PIN) begin
            gate_d = gate_pin_meta_q[1]; // RULE4
        end else if (gate_sel_q == tcs_pkg::GATE_TMR0_OVF) begin
            gate_d = gate_srcs.tmr0_ovf; // RULE5
        end else if (gate_sel_q == tcs_pkg::GATE_PERIOD) begin
            gate_d = gate_srcs.period_pulse; // RULE5
        end else if (gate_sel_q == tcs_pkg::GATE_CCP_ONE) begin
            gate_d = gate_srcs.ccp_one; // RULE5
        end else if (gate_sel_q == tcs_pkg::GATE_CCP_TWO) begin
            gate_d = gate_srcs.ccp_two; // RULE5
        end else if (gate_sel_q <= tcs_pkg::GATE_PWM_LAST) begin
            gate_d = gate_srcs.pwm[pwm_idx[1:0]]; // RULE8
        end else if (gate_sel_q == tcs_pkg::GATE_NCO) begin
            gate_d = gate_srcs.nco; // RULE8
        end else if (gate_sel_q == tcs_pkg::GATE_CMP_ONE) begin
            gate_d = gate_srcs.cmp_one; // RULE8
        end else if (gate_sel_q == tcs_pkg::GATE_CMP_TWO) begin
            gate_d = gate_srcs.cmp_two; // RULE8
        end else if (gate_sel_q == tcs_pkg::GATE_ZCD) begin
            gate_d = gate_srcs.zcd; // RULE8
        end else if (gate_sel_q <= tcs_pkg::GATE_LC_LAST) begin
            gate_d = gate_srcs.logic_cell[lc_idx_g[1:0]]; // RULE8
        end
    end

    // synchroniser stages restart empty after either reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !por_bor_rst_n) begin
            clk_pin_meta_q  <= 2'b00;
            gate_pin_meta_q <= 2'b00;
        end else begin
            clk_pin_meta_q  <= clk_pin_meta_d;
            gate_pin_meta_q <= gate_pin_meta_d;
        end
    end

    // selectors answer only to the power-on/brown-out reset; the general reset
    // idles the bus side and leaves the chosen sources in place
    always_ff @(posedge sys_clk) begin
        if (!por_bor_rst_n) begin
            clk_sel_q  <= tcs_pkg::SEL_RESET[tcs_pkg::CLK_CODE_W-1:0]; // RULE6
            gate_sel_q <= tcs_pkg::SEL_RESET[tcs_pkg::GATE_CODE_W-1:0]; // RULE6
            rdata_q    <= 32'h0000_0000;
            wait_q     <= 1'b1;
        end else if (!rst_n) begin
            rdata_q    <= 32'h0000_0000;
            wait_q     <= 1'b1;
        end else begin
            clk_sel_q  <= clk_sel_d;
            gate_sel_q <= gate_sel_d;
            rdata_q    <= rdata_d;
            wait_q     <= wait_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !por_bor_rst_n) begin
            clk_q       <= 1'b0;
            clk_valid_q <= 1'b0;
            bypass_q    <= 1'b0;
        end else begin
            clk_q       <= clk_d;
            clk_valid_q <= clk_valid_d;
            bypass_q    <= bypass_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !por_bor_rst_n) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
        end
    end

    assign avs_readdata            = rdata_q;
    assign avs_waitrequest         = wait_q;
    assign count_clock             = clk_q;
    assign count_clock_valid       = clk_valid_q;
    assign count_clock_bypass_sync = bypass_q;
    assign count_gate              = gate_q;

endmodule // tcs_source_select

`default_nettype wire

// >>> rtl/tcs_pkg.sv
package tcs_pkg;

    // register map (word offsets are byte addresses on the bus)
    localparam logic [3:0] CLK_SEL_OFFSET  = 4'h0;
    localparam logic [3:0] GATE_SEL_OFFSET = 4'h4;
    localparam logic [7:0] SEL_RESET       = 8'h00;
    localparam int         CLK_CODE_W      = 4;
    localparam int         GATE_CODE_W     = 5;

    // clock selector codes
    localparam logic [3:0] CLK_PIN       = 4'h0;
    localparam logic [3:0] CLK_SYS_DIV4  = 4'h1;
    localparam logic [3:0] CLK_SYS       = 4'h2;
    localparam logic [3:0] CLK_HFOSC     = 4'h3;
    localparam logic [3:0] CLK_LFOSC     = 4'h4;
    localparam logic [3:0] CLK_MF500K    = 4'h5;
    localparam logic [3:0] CLK_MF32K     = 4'h6;
    localparam logic [3:0] CLK_REFCLK    = 4'h8;
    localparam logic [3:0] CLK_TMR0_OVF  = 4'h9;
    localparam logic [3:0] CLK_LC_FIRST  = 4'hA;
    localparam logic [3:0] CLK_LC_LAST   = 4'hD;

    // gate selector codes
    localparam logic [4:0] GATE_PIN       = 5'h00;
    localparam logic [4:0] GATE_TMR0_OVF  = 5'h01;
    localparam logic [4:0] GATE_PERIOD    = 5'h02;
    localparam logic [4:0] GATE_CCP_ONE   = 5'h03;
    localparam logic [4:0] GATE_CCP_TWO   = 5'h04;
    localparam logic [4:0] GATE_PWM_FIRST = 5'h05;
    localparam logic [4:0] GATE_PWM_LAST  = 5'h08;
    localparam logic [4:0] GATE_NCO       = 5'h09;
    localparam logic [4:0] GATE_CMP_ONE   = 5'h0A;
    localparam logic [4:0] GATE_CMP_TWO   = 5'h0B;
    localparam logic [4:0] GATE_ZCD       = 5'h0C;
    localparam logic [4:0] GATE_LC_FIRST  = 5'h0D;
    localparam logic [4:0] GATE_LC_LAST   = 5'h10;

    typedef struct packed {
        logic       hf_osc;
        logic       lf_osc;
        logic       mf_500k;
        logic       mf_32k;
        logic       ref_clk;
        logic       tmr0_ovf;
        logic [3:0] logic_cell;
    } tcs_clk_srcs_t;

    typedef struct packed {
        logic       tmr0_ovf;
        logic       period_pulse;
        logic       ccp_one;
        logic       ccp_two;
        logic [3:0] pwm;          // pwm three .. six
        logic       nco;
        logic       cmp_one;
        logic       cmp_two;
        logic       zcd;
        logic [3:0] logic_cell;
    } tcs_gate_srcs_t;

endpackage

// >>> test/tcs_source_select_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcs_source_select_monitor (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        por_bor_rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        sync_disable,
    input wire logic        count_clock,
    input wire logic        count_clock_valid,
    input wire logic        count_clock_bypass_sync
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!(rst_n && por_bor_rst_n));
    wire req = avs_read || avs_write;
    wire ack_rd = avs_read && !avs_waitrequest;
    AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_NO_SPURIOUS: assert property (!avs_waitrequest |-> $past(req))
        else $error("answer without a request");
    AST_RD_UPPER: assert property (ack_rd |-> avs_readdata[31:5] == 27'h000_0000)
        else $error("upper read bits not zero");
    AST_RD_CLK_UPPER: assert property (ack_rd && avs_address == 4'h0 |-> !avs_readdata[4])
        else $error("clock selector bit 4 not zero");
    AST_UNMAPPED: assert property (ack_rd && !(avs_address inside {4'h0, 4'h4})
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    AST_BYPASS: assert property ($past(rst_n && por_bor_rst_n && sync_disable)
        |-> count_clock_bypass_sync) else $error("sync setting lost");
    AST_VALID_CLOCK: assert property (!count_clock_valid |-> !count_clock)
        else $error("reserved clock code drives a clock");
    AST_SYS_VALID: assert property (count_clock_bypass_sync
        && $past(rst_n && por_bor_rst_n && !sync_disable) |-> count_clock_valid)
        else $error("bypass on bad code");
    cover property (avs_write && !avs_waitrequest);
    cover property (ack_rd && avs_address == 4'h4);
    cover property ($fell(count_clock_valid));
endmodule // tcs_source_select_monitor
bind tcs_source_select tcs_source_select_monitor i_mon (.sys_clk, .rst_n, .por_bor_rst_n,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .sync_disable,
    .count_clock, .count_clock_valid, .count_clock_bypass_sync);
`default_nettype wire

// >>> test/tcs_source_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcs_source_select_tb;
    logic                    sys_clk, rst_n, por_bor_rst_n, avs_read, avs_write, avs_waitrequest;
    logic                    sync_disable, clock_pin_input_map, gate_pin_input_map, sys_div4_tick;
    logic                    count_clock, count_clock_valid, count_clock_bypass_sync, count_gate;
    logic [3:0]              avs_address, avs_byteenable, mclk;
    logic [4:0]              mgate;
    logic [15:0]             cv;
    logic [31:0]             avs_writedata, avs_readdata, q, gv;
    tcs_pkg::tcs_clk_srcs_t  clk_srcs;
    tcs_pkg::tcs_gate_srcs_t gate_srcs;
    int                      err_count = 0, checked = 0, cycles = 0;
    tcs_source_select i_dut (.sys_clk, .rst_n, .por_bor_rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sync_disable, .clock_pin_input_map, .gate_pin_input_map, .sys_div4_tick, .clk_srcs,
        .gate_srcs, .count_clock, .count_clock_valid, .count_clock_bypass_sync, .count_gate);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one access; the model takes a write only when the slave accepts it
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge sys_clk);
        {avs_write, avs_read} <= {w, !w};
        {avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        if (w && be[0] && a == tcs_pkg::CLK_SEL_OFFSET)
            mclk = d[3:0];
        if (w && be[0] && a == tcs_pkg::GATE_SEL_OFFSET)
            mgate = d[4:0];
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(q, a == 4'h0 ? 32'(mclk) : a == 4'h4 ? 32'(mgate) : 32'h0000_0000);
    endtask
    task automatic try(input logic [3:0] a, input logic [4:0] code);
        logic [31:0] d;
        d = $urandom;
        d[4:0] = code;
        bus(1'b1, a, d, 4'($urandom) | 4'h1);
        rd(a);
        clk_srcs <= 10'($urandom);
        gate_srcs <= 17'($urandom);
        {sync_disable, clock_pin_input_map, gate_pin_input_map, sys_div4_tick} <= 4'($urandom);
        // pins need two sync stages plus the output register
        repeat (5) @(posedge sys_clk);
        cv = {2'b00, clk_srcs.logic_cell, clk_srcs.tmr0_ovf, clk_srcs.ref_clk, 1'b0,
              clk_srcs.mf_32k, clk_srcs.mf_500k, clk_srcs.lf_osc, clk_srcs.hf_osc, 1'b1,
              sys_div4_tick, clock_pin_input_map};
        gv = {15'h0000, gate_srcs.logic_cell, gate_srcs.zcd, gate_srcs.cmp_two,
              gate_srcs.cmp_one, gate_srcs.nco, gate_srcs.pwm, gate_srcs.ccp_two,
              gate_srcs.ccp_one, gate_srcs.period_pulse, gate_srcs.tmr0_ovf, gate_pin_input_map};
        chk(32'(count_clock), 32'(cv[mclk]));
        chk(32'(count_clock_valid), 32'(!(mclk inside {4'h7, 4'hE, 4'hF})));
        chk(32'(count_clock_bypass_sync),
            32'((mclk inside {4'h1, 4'h2}) || sync_disable));
        chk(32'(count_gate), 32'(gv[mgate]));
    endtask
    initial begin
        void'($urandom(55));
        {rst_n, por_bor_rst_n, avs_read, avs_write, mclk, mgate} = '0;
        {avs_address, avs_writedata, avs_byteenable, clk_srcs, gate_srcs} = '0;
        {sync_disable, clock_pin_input_map, gate_pin_input_map, sys_div4_tick} = '0;
        repeat (16) @(posedge sys_clk);
        {rst_n, por_bor_rst_n} <= 2'b11;
        rd(4'h0);
        rd(4'h4);
        for (int c = 0; c < 16; c++)
            try(4'h0, 5'(c));
        for (int c = 0; c < 32; c++)
            try(4'h4, 5'(c));
        try(4'h8, 5'($urandom));
        bus(1'b1, 4'h0, 32'h0000_0003, 4'hE);
        rd(4'h0);
        // general reset must leave both selectors alone
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(4'h0);
        rd(4'h4);
        por_bor_rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        por_bor_rst_n <= 1'b1;
        {mclk, mgate} = '0;
        rd(4'h0);
        rd(4'h4);
        tally_and_finish();
    end
endmodule // tcs_source_select_tb
`default_nettype wire
